// file: core/esr_top.sv
// esr_top: error status flags register with message requests toward the chipset link.
// assumes a simple 16-bit config port, power-good reset for sticky flags, async event pins.
`timescale 1ns/1ns
`default_nettype none
module esr_top
   import esr_pkg::*;
#(
   parameter bit HAS_GFX = 1'b1
) (
   input wire logic I_CLK_SYS,
   input wire logic I_RST_B,
   input wire logic I_PWRGOOD_RST_B,
   input wire logic I_CFG_WR,
   input wire logic I_CFG_RD,
   input wire logic [7:0] I_CFG_ADDR,
   input wire logic [1:0] I_CFG_BE,
   input wire logic [15:0] I_CFG_WDATA,
   output logic [15:0] O_CFG_RDATA,
   input wire logic I_SERR_GLOBAL_EN,
   input wire logic I_GFX_SW_SMI,
   input wire logic I_THERMAL_TRIP,
   input wire logic I_THERMAL_SMI_EN,
   input wire logic I_THERMAL_SCI_EN,
   input wire logic I_LOCK_NON_DRAM,
   input wire logic I_DRAM_THROTTLE,
   output logic O_LINK_SERR_REQ,
   output logic O_LINK_THERMAL_SMI_REQ,
   output logic O_LINK_THERMAL_SCI_REQ
);
   logic [3:0] ev_async;
   logic [3:0] ev_sync;
   logic [3:0] ev_prev_q;
   logic [15:0] flags_q;
   logic [15:0] flags_d;
   logic [15:0] prev_flags_q;
   logic [15:0] enables_q;
   logic [15:0] rdata_q;
   logic serr_q;
   logic smi_q;
   logic sci_q;

   assign ev_async = {I_GFX_SW_SMI, I_THERMAL_TRIP, I_LOCK_NON_DRAM, I_DRAM_THROTTLE};

   esr_sync #(.W(ESR_NUM_FLAGS)) u_sync (
      .i_clk(I_CLK_SYS),
      .i_rst_b(I_RST_B),
      .i_async(ev_async),
      .o_sync(ev_sync)
   );

   always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
      if (!I_RST_B) begin
         ev_prev_q <= '0;
      end else begin
         ev_prev_q <= ev_sync;
      end
   end

   wire [3:0] ev_rise = ev_sync & ~ev_prev_q;
   wire flags_hit = (I_CFG_ADDR == ESR_FLAGS_OFS);
   wire enables_hit = (I_CFG_ADDR == ESR_ENABLES_OFS);
   wire [15:0] be_mask = {{8{I_CFG_BE[1]}}, {8{I_CFG_BE[0]}}};
   wire [15:0] clr_mask = (I_CFG_WR && flags_hit) ? (I_CFG_WDATA & be_mask & ESR_FLAG_MASK) : 16'h0000;
   wire thermal_flag = flags_q[ESR_BIT_THERMAL];
   wire therm_serr_en = enables_q[ESR_BIT_THERMAL] && I_SERR_GLOBAL_EN;
   wire therm_fire = ev_rise[2] && !thermal_flag &&
      (therm_serr_en || I_THERMAL_SMI_EN || I_THERMAL_SCI_EN);
   wire gfx_set = HAS_GFX && ev_rise[3];

   logic [15:0] set_mask;
   always_comb begin
      set_mask = 16'h0000;
      set_mask[ESR_BIT_GFX_SMI] = gfx_set;
      set_mask[ESR_BIT_THERMAL] = therm_fire;
      set_mask[ESR_BIT_LOCK] = ev_rise[1];
      set_mask[ESR_BIT_THROTTLE] = ev_rise[0];
   end

   assign flags_d = ((flags_q & ~clr_mask) | set_mask) & ESR_FLAG_MASK;

   always_ff @(posedge I_CLK_SYS or negedge I_PWRGOOD_RST_B) begin
      if (!I_PWRGOOD_RST_B) begin
         flags_q <= ESR_FLAGS_RST;
         prev_flags_q <= ESR_FLAGS_RST;
      end else begin
         flags_q <= flags_d;
         prev_flags_q <= flags_q;
      end
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
      if (!I_RST_B) begin
         enables_q <= ESR_ENABLES_RST;
      end else if (I_CFG_WR && enables_hit) begin
         enables_q <= (enables_q & ~be_mask) | (I_CFG_WDATA & be_mask & ESR_ENABLE_MASK);
      end
   end

   wire [15:0] flag_rise = flags_q & ~prev_flags_q;
   wire serr_d = I_SERR_GLOBAL_EN && |(flag_rise & enables_q);
   wire smi_d = therm_fire && I_THERMAL_SMI_EN;
   wire sci_d = therm_fire && I_THERMAL_SCI_EN;

   wire [15:0] rd_mux = flags_hit ? flags_q : (enables_hit ? enables_q : 16'h0000);

   always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
      if (!I_RST_B) begin
         serr_q <= 1'b0;
         smi_q <= 1'b0;
         sci_q <= 1'b0;
         rdata_q <= 16'h0000;
      end else begin
         serr_q <= serr_d;
         smi_q <= smi_d;
         sci_q <= sci_d;
         rdata_q <= I_CFG_RD ? rd_mux : 16'h0000;
      end
   end

   assign O_LINK_SERR_REQ = serr_q;
   assign O_LINK_THERMAL_SMI_REQ = smi_q;
   assign O_LINK_THERMAL_SCI_REQ = sci_q;
   assign O_CFG_RDATA = rdata_q;

   a_serr_on_rise: assert property (
      @(posedge I_CLK_SYS) disable iff (!I_RST_B || !I_PWRGOOD_RST_B)
      (I_SERR_GLOBAL_EN && |(flags_q & ~prev_flags_q & enables_q)) |=> O_LINK_SERR_REQ)
      else $error("serr request missing after enabled flag rise");
   a_serr_no_cause: assert property (
      @(posedge I_CLK_SYS) disable iff (!I_RST_B || !I_PWRGOOD_RST_B)
      O_LINK_SERR_REQ |-> $past(I_SERR_GLOBAL_EN))
      else $error("serr request without global enable");
   a_flag_sets: assert property (
      @(posedge I_CLK_SYS) disable iff (!I_RST_B || !I_PWRGOOD_RST_B)
      ev_rise[1] |=> flags_q[ESR_BIT_LOCK])
      else $error("lock flag not set on event");
   a_clear_one: assert property (
      @(posedge I_CLK_SYS) disable iff (!I_RST_B || !I_PWRGOOD_RST_B)
      (clr_mask[ESR_BIT_THROTTLE] && !ev_rise[0]) |=> !flags_q[ESR_BIT_THROTTLE])
      else $error("throttle flag not cleared by write one");
   a_gfx_absent: assert property (
      @(posedge I_CLK_SYS) disable iff (!I_PWRGOOD_RST_B)
      !HAS_GFX |-> !flags_q[ESR_BIT_GFX_SMI])
      else $error("graphics flag set on variant without graphics");
   a_therm_needs_msg: assert property (
      @(posedge I_CLK_SYS) disable iff (!I_RST_B || !I_PWRGOOD_RST_B)
      $rose(flags_q[ESR_BIT_THERMAL]) |-> $past(therm_fire))
      else $error("thermal flag set without notification");
   a_therm_quiet: assert property (
      @(posedge I_CLK_SYS) disable iff (!I_RST_B || !I_PWRGOOD_RST_B)
      (thermal_flag && $past(thermal_flag)) |=> !O_LINK_THERMAL_SMI_REQ && !O_LINK_THERMAL_SCI_REQ)
      else $error("thermal message while thermal flag set");
   a_reserved_zero: assert property (
      @(posedge I_CLK_SYS) disable iff (!I_PWRGOOD_RST_B)
      (flags_q & ~ESR_FLAG_MASK) == 16'h0000)
      else $error("reserved flag bit nonzero");
   a_throttle_stays: assert property (
      @(posedge I_CLK_SYS) disable iff (!I_PWRGOOD_RST_B)
      (flags_q[ESR_BIT_THROTTLE] && !clr_mask[ESR_BIT_THROTTLE]) |=> flags_q[ESR_BIT_THROTTLE])
      else $error("throttle flag dropped without clear");
   a_smi_single: assert property (
      @(posedge I_CLK_SYS) disable iff (!I_RST_B || !I_PWRGOOD_RST_B)
      O_LINK_THERMAL_SMI_REQ |=> !O_LINK_THERMAL_SMI_REQ)
      else $error("thermal smi request longer than one cycle");
   a_sci_single: assert property (
      @(posedge I_CLK_SYS) disable iff (!I_RST_B || !I_PWRGOOD_RST_B)
      O_LINK_THERMAL_SCI_REQ |=> !O_LINK_THERMAL_SCI_REQ)
      else $error("thermal sci request longer than one cycle");
   a_smi_needs_en: assert property (
      @(posedge I_CLK_SYS) disable iff (!I_RST_B || !I_PWRGOOD_RST_B)
      O_LINK_THERMAL_SMI_REQ |-> $past(I_THERMAL_SMI_EN) && flags_q[ESR_BIT_THERMAL])
      else $error("thermal smi request without enable or flag");
   a_sci_needs_en: assert property (
      @(posedge I_CLK_SYS) disable iff (!I_RST_B || !I_PWRGOOD_RST_B)
      O_LINK_THERMAL_SCI_REQ |-> $past(I_THERMAL_SCI_EN) && flags_q[ESR_BIT_THERMAL])
      else $error("thermal sci request without enable or flag");
   a_enables_reserved: assert property (
      @(posedge I_CLK_SYS) disable iff (!I_RST_B)
      (enables_q & ~ESR_ENABLE_MASK) == 16'h0000)
      else $error("reserved enable bit nonzero");
   a_write_zero_keeps: assert property (
      @(posedge I_CLK_SYS) disable iff (!I_RST_B || !I_PWRGOOD_RST_B)
      (I_CFG_WR && I_CFG_ADDR == ESR_FLAGS_OFS && flags_q[ESR_BIT_LOCK] &&
         !(I_CFG_BE[1] && I_CFG_WDATA[ESR_BIT_LOCK])) |=> flags_q[ESR_BIT_LOCK])
      else $error("lock flag lost on write of zero");
   a_warm_keeps: assert property (
      @(posedge I_CLK_SYS) disable iff (!I_PWRGOOD_RST_B)
      (!I_RST_B && !I_CFG_WR) |=> flags_q == $past(flags_q))
      else $error("flags changed under warm reset");
   a_rdata_unmapped: assert property (
      @(posedge I_CLK_SYS) disable iff (!I_RST_B)
      (I_CFG_RD && I_CFG_ADDR != ESR_FLAGS_OFS && I_CFG_ADDR != ESR_ENABLES_OFS) |=> O_CFG_RDATA == 16'h0000)
      else $error("unmapped read returned nonzero");
   a_throttle_sets: assert property (
      @(posedge I_CLK_SYS) disable iff (!I_RST_B || !I_PWRGOOD_RST_B)
      ev_rise[0] |=> flags_q[ESR_BIT_THROTTLE])
      else $error("throttle flag not set on event");
   a_gfx_sets: assert property (
      @(posedge I_CLK_SYS) disable iff (!I_RST_B || !I_PWRGOOD_RST_B)
      (HAS_GFX && ev_rise[3]) |=> flags_q[ESR_BIT_GFX_SMI])
      else $error("graphics flag not set on event");
endmodule
`default_nettype wire

// file: pkg/esr_pkg.sv
// esr_pkg: offsets, bit positions and reset values for the error status flags.
// assumes a 16-bit configuration register access port with byte enables.
package esr_pkg;
   localparam logic [7:0] ESR_FLAGS_OFS = 8'hc8;
   localparam logic [7:0] ESR_ENABLES_OFS = 8'hca;
   localparam int ESR_BIT_GFX_SMI = 12;
   localparam int ESR_BIT_THERMAL = 11;
   localparam int ESR_BIT_LOCK = 9;
   localparam int ESR_BIT_THROTTLE = 7;
   localparam int ESR_NUM_FLAGS = 4;
   localparam logic [15:0] ESR_FLAGS_RST = 16'h0000;
   localparam logic [15:0] ESR_ENABLES_RST = 16'h0000;
   localparam logic [15:0] ESR_FLAG_MASK = 16'h1a80;
   localparam logic [15:0] ESR_ENABLE_MASK = 16'h0a80;
   localparam int ESR_SYNC_STAGES = 2;
endpackage

// file: core/esr_sync.sv
// esr_sync: two-flop synchroniser for a bundle of asynchronous event levels.
// assumes events are levels held for at least two clock periods.
`timescale 1ns/1ns
`default_nettype none
module esr_sync #(
   parameter int W = 4
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end
   assign o_sync = sync_q;
endmodule
`default_nettype wire

// file: sim/esr_hub_model.sv
// esr_hub_model: far-side hub counting message requests.
// assumes one-cycle request pulses on the block clock.
`timescale 1ns/1ns
`default_nettype none
module esr_hub_model (
   input wire logic i_clk,
   input wire logic i_serr_req,
   input wire logic i_smi_req,
   input wire logic i_sci_req,
   output var integer o_serr_cnt = 0,
   output var integer o_smi_cnt = 0,
   output var integer o_sci_cnt = 0
);
   always @(posedge i_clk) begin
      o_serr_cnt <= o_serr_cnt + i_serr_req;
      o_smi_cnt <= o_smi_cnt + i_smi_req;
      o_sci_cnt <= o_sci_cnt + i_sci_req;
   end
endmodule
`default_nettype wire

// file: sim/esr_top_tb.sv
// esr_top_tb: self-checking bench for the error status flags block.
// assumes esr_pkg and esr_hub_model compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; \
   $display("[ERR] %0t got %h want %h", $time, a, e); end end
module esr_top_tb;
   import esr_pkg::*;
   logic I_CLK_SYS = 1'h0, I_RST_B = 1'h0, I_PWRGOOD_RST_B = 1'h0, I_CFG_WR = 1'h0, I_CFG_RD = 1'h0;
   logic glb = 1'h0, smi_en = 1'h0, sci_en = 1'h0;
   logic [7:0] I_CFG_ADDR = 8'h00;
   logic [1:0] I_CFG_BE = 2'h0;
   logic [15:0] I_CFG_WDATA = 16'h0000, ev = 16'h0000, rd;
   logic [31:0] r;
   wire logic [15:0] O_CFG_RDATA;
   wire logic serr, smi, sci;
   integer sc, mc, cc;
   int fl = 0, en = 0, ns = 0, nm = 0, nc = 0, err_count = 0, check_count = 0, seed = 79963;
   int bits[6] = '{12, 11, 9, 7, 9, 11};
   always #10 I_CLK_SYS = ~I_CLK_SYS;
   esr_top esr_top_inst (.I_CLK_SYS, .I_RST_B, .I_PWRGOOD_RST_B, .I_CFG_WR, .I_CFG_RD, .I_CFG_ADDR, .I_CFG_BE,
      .I_CFG_WDATA, .O_CFG_RDATA, .I_SERR_GLOBAL_EN(glb), .I_GFX_SW_SMI(ev[12]), .I_THERMAL_TRIP(ev[11]),
      .I_THERMAL_SMI_EN(smi_en), .I_THERMAL_SCI_EN(sci_en), .I_LOCK_NON_DRAM(ev[9]), .I_DRAM_THROTTLE(ev[7]),
      .O_LINK_SERR_REQ(serr), .O_LINK_THERMAL_SMI_REQ(smi), .O_LINK_THERMAL_SCI_REQ(sci));
   esr_hub_model esr_hub_model_inst (.i_clk(I_CLK_SYS), .i_serr_req(serr), .i_smi_req(smi), .i_sci_req(sci),
      .o_serr_cnt(sc), .o_smi_cnt(mc), .o_sci_cnt(cc));
   task automatic cfg(input logic w, input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
      @(posedge I_CLK_SYS);
      I_CFG_WR <= w;
      I_CFG_RD <= !w;
      I_CFG_ADDR <= a;
      I_CFG_BE <= be;
      I_CFG_WDATA <= d;
      @(posedge I_CLK_SYS);
      I_CFG_WR <= 1'h0;
      I_CFG_RD <= 1'h0;
      @(negedge I_CLK_SYS);
      rd = O_CFG_RDATA;
   endtask
   task automatic wr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
      logic [15:0] bm;
      bm = {{8{be[1]}}, {8{be[0]}}};
      cfg(1'h1, a, be, d);
      if (a == ESR_FLAGS_OFS) fl = fl & ~(d & bm & ESR_FLAG_MASK);
      if (a == ESR_ENABLES_OFS) en = (en & ~bm) | (d & bm & ESR_ENABLE_MASK);
   endtask
   task automatic rdc(input logic [7:0] a);
      cfg(1'h0, a, 2'h3, 16'h0000);
      `CHK(rd, a == ESR_FLAGS_OFS ? fl[15:0] : a == ESR_ENABLES_OFS ? en[15:0] : 16'h0000)
   endtask
   task automatic fire(input int b);
      // message only on 0 to 1
      if (b != 11 && !fl[b]) ns += (b != 12) && en[b] && glb;
      if (b == 11 && !fl[b] && (en[b] && glb || smi_en || sci_en)) begin
         ns += en[b] && glb;
         nm += smi_en;
         nc += sci_en;
      end
      fl[b] = fl[b] | (b != 11) | (en[b] & glb) | smi_en | sci_en;
      @(posedge I_CLK_SYS);
      ev[b] <= 1'h1;
      repeat (6) @(posedge I_CLK_SYS);
      ev[b] <= 1'h0;
      repeat (4) @(posedge I_CLK_SYS);
      `CHK(sc, ns)
      `CHK(mc, nm)
      `CHK(cc, nc)
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      #(20 * 3000);
      err_count++;
      tally_and_finish();
   end
   initial begin
      repeat (8) @(posedge I_CLK_SYS);
      I_RST_B <= 1'h1;
      I_PWRGOOD_RST_B <= 1'h1;
      glb <= 1'h1;
      rdc(ESR_FLAGS_OFS);
      wr(ESR_ENABLES_OFS, 2'h3, 16'hffff);
      rdc(ESR_ENABLES_OFS);
      foreach (bits[i]) fire(bits[i]);
      rdc(ESR_FLAGS_OFS);
      wr(8'hcc, 2'h3, 16'hffff);
      rdc(8'hcc);
      rdc(ESR_FLAGS_OFS);
      $display("test events done");
      repeat (6) begin
         r = $random(seed);
         wr(ESR_FLAGS_OFS, r[17:16], r[15:0]);
         rdc(ESR_FLAGS_OFS);
         wr(ESR_ENABLES_OFS, r[31:30], r[31:16]);
         rdc(ESR_ENABLES_OFS);
      end
      wr(ESR_FLAGS_OFS, 2'h3, 16'hffff);
      @(posedge I_CLK_SYS);
      glb <= 1'h0;
      rdc(ESR_FLAGS_OFS);
      foreach (bits[i]) fire(bits[i]);
      $display("test clears done");
      @(posedge I_CLK_SYS);
      smi_en <= 1'h1;
      rdc(ESR_FLAGS_OFS);
      fire(11);
      wr(ESR_FLAGS_OFS, 2'h2, 16'h0800);
      @(posedge I_CLK_SYS);
      smi_en <= 1'h0;
      sci_en <= 1'h1;
      rdc(ESR_FLAGS_OFS);
      fire(11);
      $display("test routing done");
      @(posedge I_CLK_SYS);
      ev[7] <= 1'h1;
      @(posedge I_CLK_SYS);
      wr(ESR_FLAGS_OFS, 2'h1, 16'h0080);
      // event and clear together, set wins
      fl[7] = 1'h1;
      @(posedge I_CLK_SYS);
      ev[7] <= 1'h0;
      rdc(ESR_FLAGS_OFS);
      @(posedge I_CLK_SYS);
      I_RST_B <= 1'h0;
      repeat (2) @(posedge I_CLK_SYS);
      I_RST_B <= 1'h1;
      en = 0;
      rdc(ESR_FLAGS_OFS);
      rdc(ESR_ENABLES_OFS);
      @(posedge I_CLK_SYS);
      I_PWRGOOD_RST_B <= 1'h0;
      repeat (2) @(posedge I_CLK_SYS);
      I_PWRGOOD_RST_B <= 1'h1;
      fl = 0;
      rdc(ESR_FLAGS_OFS);
      $display("test resets done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
